// *** fts_pkg.sv ***
`default_nettype none
package fts_pkg;

	// Register index on the internal register port behind the serial interface.
	localparam int FTS_ADDR_W = 3;
	localparam logic [FTS_ADDR_W-1:0] FTS_OFS_CONFIG = 3'h0;
	localparam logic [FTS_ADDR_W-1:0] FTS_OFS_BYTE_ZERO = 3'h1;
	localparam logic [FTS_ADDR_W-1:0] FTS_OFS_BYTE_ONE = 3'h2;
	localparam logic [FTS_ADDR_W-1:0] FTS_OFS_BYTE_TWO = 3'h3;
	localparam logic [FTS_ADDR_W-1:0] FTS_OFS_BYTE_THREE = 3'h4;

	// Reset values and the writable part of the configuration byte.
	localparam logic [7:0] FTS_CFG_RESET = 8'h00;
	localparam logic [7:0] FTS_CFG_RW_MASK = 8'h1F;
	localparam logic [31:0] FTS_CNT_RESET = 32'h0000_0000;

	// Clock rates: the counter advances at 32 MHz out of the 50 MHz system clock.
	localparam int FTS_MCLK_MHZ = 50;
	localparam int FTS_CNT_MHZ = 32;
	localparam int FTS_PHASE_W = 6;

	// Fixed baseband transmit delay from command to transmit start.
	localparam int FTS_MCLK_PERIOD_NS = 20;
	localparam int FTS_TX_BB_DELAY_NS = 4000;
	localparam int FTS_TX_BB_DELAY_CYC = FTS_TX_BB_DELAY_NS / FTS_MCLK_PERIOD_NS;

	// Configuration byte layout, most significant field first.
	typedef struct packed {
		logic [2:0] reserved;
		logic capture_on_tx_start;
		logic capture_on_rx_start;
		logic clear_on_tx_start;
		logic clear_on_rx_start;
		logic enable;
	} fts_cfg_s;

	// Transmit sequencing, Gray coded along idle, delay, on.
	typedef enum logic [1:0] {
		FTS_TX_IDLE = 2'b00,
		FTS_TX_DELAY = 2'b01,
		FTS_TX_ON = 2'b11
	} fts_tx_e;

endpackage
`default_nettype wire

// *** fts_timestamp_counter.sv ***
// Overview of operation
// (RQ1) The 32-bit count is shown as four byte registers, byte zero holding bits 7:0 up to byte three holding bits 31:24.
// (RQ2) A consistent value is guaranteed only when the host reads all four bytes in one block starting at byte zero.
// (RQ3) With enable set the counter runs, with enable clear it is stopped and held at zero.
// (RQ4) The counter clears to zero on a receive frame start or transmit start when the matching clear bit is set.
// (RQ5) An enabled counter does not advance while the transceiver is in reset, sleep or deep sleep.
// (RQ6) The counter advances once per 32 MHz period.
// (RQ7) From its maximum value the counter wraps to zero on the next count.
// (RQ8) With both capture bits clear the count registers show the live counter.
// (RQ9) With any capture bit set the count registers show the last captured value.
// (RQ10) Capture on transmit copies the counter at the rising edge of the power amplifier enable.
// (RQ11) Capture on receive copies the counter at the receive frame start event.
// (RQ12) The transmit start event comes a fixed baseband delay after the transmit command.
// (RQ13) The configuration byte holds capture-tx, capture-rx, clear-tx, clear-rx and enable in bits 4 to 0, reset 0, bits 7:5 read zero.
// (RQ14) A read of byte zero latches all four bytes into a shadow so the later bytes match it.
// (RQ15) When capture and clear hit on the same event, the value before the clear is captured.
`default_nettype none
module fts_timestamp_counter
	import fts_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Register port from the serial interface.
	input wire logic [FTS_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Transceiver events and state.
	input wire logic trx_halted,
	input wire logic tx_cmd_strobe,
	input wire logic tx_done,
	input wire logic rx_frame_start_irq,
	output logic pa_enable
);

	fts_cfg_s cfg_q;
	logic [31:0] cnt_q;
	logic [31:0] capt_q;
	logic [31:0] shadow_q;
	logic [FTS_PHASE_W-1:0] phase_q;
	logic [FTS_PHASE_W:0] phase_sum;
	logic tick;
	fts_tx_e tx_state_q;
	logic [15:0] dly_q;
	logic pa_q;
	logic pa_prev_q;
	logic tx_start;
	logic capture_mode;
	logic clear_evt;
	logic capture_evt;
	logic [31:0] view;
	logic [7:0] rdata_q;

	// Picks one byte out of a word, byte zero being the least significant.
	function automatic logic [7:0] fts_byte(input logic [31:0] word, input logic [1:0] idx);
		fts_byte = word[8*idx +: 8];
	endfunction

	// Register writes; only the five low bits are stored, the rest stay zero.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cfg_q <= fts_cfg_s'(FTS_CFG_RESET);
		else if (reg_wr && reg_addr == FTS_OFS_CONFIG)
			cfg_q <= fts_cfg_s'(reg_wdata & FTS_CFG_RW_MASK); // RQ13
	end

	// Fractional divider: adds 32 per 50 MHz cycle and ticks on every wrap past 50.
	// The ticks jitter by one system cycle but average exactly 32 MHz.
	assign phase_sum = {1'b0, phase_q} + 7'(FTS_CNT_MHZ);
	assign tick = phase_sum >= 7'(FTS_MCLK_MHZ); // RQ6

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			phase_q <= '0;
		else if (tick)
			phase_q <= FTS_PHASE_W'(phase_sum - 7'(FTS_MCLK_MHZ));
		else
			phase_q <= FTS_PHASE_W'(phase_sum);
	end

	// Transmit sequencer: holds off the amplifier for the baseband delay after the command.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tx_state_q <= FTS_TX_IDLE;
			dly_q <= '0;
			pa_q <= 1'b0;
		end
		else
		begin
			case (tx_state_q)
				FTS_TX_IDLE:
					if (tx_cmd_strobe)
					begin
						tx_state_q <= FTS_TX_DELAY;
						dly_q <= 16'(FTS_TX_BB_DELAY_CYC - 1); // RQ12
					end
				FTS_TX_DELAY:
					if (dly_q <= 16'h0001)
					begin
						tx_state_q <= FTS_TX_ON;
						pa_q <= 1'b1; // RQ12
					end
					else
						dly_q <= dly_q - 16'h0001;
				FTS_TX_ON:
					if (tx_done)
					begin
						tx_state_q <= FTS_TX_IDLE;
						pa_q <= 1'b0;
					end
				default:
				begin
					tx_state_q <= FTS_TX_IDLE;
					pa_q <= 1'b0;
				end
			endcase
		end
	end

	// Edge memory for the amplifier enable, which marks the transmit start.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pa_prev_q <= 1'b0;
		else
			pa_prev_q <= pa_q;
	end

	assign tx_start = pa_q && !pa_prev_q; // RQ10
	assign clear_evt = (cfg_q.clear_on_tx_start && tx_start) ||
		(cfg_q.clear_on_rx_start && rx_frame_start_irq); // RQ4
	assign capture_evt = (cfg_q.capture_on_tx_start && tx_start) ||
		(cfg_q.capture_on_rx_start && rx_frame_start_irq); // RQ10 RQ11
	assign capture_mode = cfg_q.capture_on_tx_start || cfg_q.capture_on_rx_start;

	// The counter itself; plain 32-bit addition wraps from all ones to zero.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cnt_q <= FTS_CNT_RESET;
		else if (!cfg_q.enable)
			cnt_q <= FTS_CNT_RESET; // RQ3
		else if (clear_evt)
			cnt_q <= FTS_CNT_RESET; // RQ4
		else if (tick && !trx_halted)
			cnt_q <= cnt_q + 32'h0000_0001; // RQ5 RQ6 RQ7
	end

	// Capture takes the counter as it stands, so a clear in the same cycle comes after it.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			capt_q <= FTS_CNT_RESET;
		else if (capture_evt)
			capt_q <= cnt_q; // RQ10 RQ11 RQ15
	end

	assign view = capture_mode ? capt_q : cnt_q; // RQ8 RQ9

	// Byte zero read freezes the whole word; a read in another order may mix two instants.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			shadow_q <= FTS_CNT_RESET;
		else if (reg_rd && reg_addr == FTS_OFS_BYTE_ZERO)
			shadow_q <= view; // RQ14 RQ2
	end

	// Read data, one cycle after the strobe; unmapped indices read zero.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				FTS_OFS_CONFIG: rdata_q <= cfg_q; // RQ13
				FTS_OFS_BYTE_ZERO: rdata_q <= fts_byte(view, 2'd0); // RQ1
				FTS_OFS_BYTE_ONE: rdata_q <= fts_byte(shadow_q, 2'd1); // RQ1
				FTS_OFS_BYTE_TWO: rdata_q <= fts_byte(shadow_q, 2'd2); // RQ1
				FTS_OFS_BYTE_THREE: rdata_q <= fts_byte(shadow_q, 2'd3); // RQ1
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign pa_enable = pa_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_tx_cmd;
		tx_state_q == FTS_TX_IDLE && tx_cmd_strobe;
	endsequence

	sequence s_pa_wait;
		!pa_q [*8];
	endsequence

	a_off_holds_zero: assert property (!cfg_q.enable |=> cnt_q == 32'h0000_0000) // RQ3
		else $error("Disabled counter is not zero.");

	a_count_step_wraps: assert property (
		cfg_q.enable && tick && !trx_halted && !clear_evt
		|=> cnt_q == 32'($past(cnt_q) + 32'h0000_0001)) // RQ6 RQ7
		else $error("Counter did not step by one.");

	a_halt_no_advance: assert property (
		cfg_q.enable && trx_halted && !clear_evt |=> cnt_q == $past(cnt_q)) // RQ5
		else $error("Counter advanced while halted.");

	a_event_clears: assert property (cfg_q.enable && clear_evt |=> cnt_q == 32'h0000_0000) // RQ4
		else $error("Event clear did not zero the counter.");

	a_capture_pre_clear: assert property (capture_evt |=> capt_q == $past(cnt_q)) // RQ15 RQ10
		else $error("Capture did not take the pre-clear value.");

	a_rx_capture: assert property (
		cfg_q.capture_on_rx_start && rx_frame_start_irq |=> capt_q == $past(cnt_q)) // RQ11
		else $error("Receive start was not captured.");

	a_free_read_live: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_ZERO && !capture_mode
		|=> reg_rdata == $past(cnt_q[7:0])) // RQ8
		else $error("Free running read is not the live count.");

	a_capture_read_held: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_ZERO && capture_mode
		|=> reg_rdata == $past(capt_q[7:0])) // RQ9
		else $error("Capture mode read is not the captured value.");

	a_block_read_shadow: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_THREE
		|=> reg_rdata == $past(shadow_q[31:24])) // RQ14 RQ1 RQ2
		else $error("Upper byte does not match the byte zero instant.");

	a_config_write_mask: assert property (
		reg_wr && reg_addr == FTS_OFS_CONFIG |=> cfg_q == ($past(reg_wdata) & FTS_CFG_RW_MASK)) // RQ13
		else $error("Configuration write stored wrong bits.");

	a_tx_delay_time: assert property (s_tx_cmd |=> s_pa_wait ##192 pa_q && !pa_prev_q) // RQ12
		else $error("Transmit start not at the baseband delay.");

	// Upper configuration bits have no storage behind them and must stay zero.
	a_cfg_top_zero: assert property (cfg_q.reserved == 3'b000) // RQ13
		else $error("Reserved configuration bits are set.");

	// Byte one comes from the shadow, never from the moving counter.
	a_byte_one_shadow: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_ONE
		|=> reg_rdata == $past(shadow_q[15:8])) // RQ1 RQ14
		else $error("Byte one is not taken from the shadow.");

	// Byte two comes from the shadow as well, so a carry between reads cannot tear it.
	a_byte_two_shadow: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_TWO
		|=> reg_rdata == $past(shadow_q[23:16])) // RQ1 RQ14
		else $error("Byte two is not taken from the shadow.");

	// A byte zero read freezes the word seen at that very edge.
	a_shadow_latch: assert property (
		reg_rd && reg_addr == FTS_OFS_BYTE_ZERO |=> shadow_q == $past(view)) // RQ14 RQ2
		else $error("Shadow did not latch the byte zero instant.");

	// Without an event the captured word must not move.
	a_capture_stays: assert property (!capture_evt |=> capt_q == $past(capt_q)) // RQ9
		else $error("Captured value changed without an event.");

	// Between ticks an enabled counter holds still, so the rate is that of the divider.
	a_no_tick_hold: assert property (
		cfg_q.enable && !tick && !clear_evt |=> cnt_q == $past(cnt_q)) // RQ6
		else $error("Counter moved without a tick.");

	// The divider phase never reaches the system rate, else a tick would be lost.
	a_divider_bound: assert property (phase_q < 6'(FTS_MCLK_MHZ)) // RQ6
		else $error("Divider phase out of range.");

	// The amplifier stays on until the end of transmission.
	a_pa_holds: assert property (tx_state_q == FTS_TX_ON && !tx_done |=> pa_q) // RQ10
		else $error("Amplifier dropped before the end of transmission.");

	// A transmit start lasts one cycle, so capture and clear act once per frame.
	a_tx_start_once: assert property (tx_start |=> !tx_start) // RQ10
		else $error("Transmit start lasted more than one cycle.");

	// The delay keeps running whatever else arrives, so repeated commands cannot stretch it.
	a_delay_counts: assert property (
		tx_state_q == FTS_TX_DELAY && dly_q > 16'h0001
		|=> tx_state_q == FTS_TX_DELAY && dly_q == $past(dly_q) - 16'h0001) // RQ12
		else $error("Transmit delay did not count down.");

	// Indices past the last count byte read as zero.
	a_unmapped_zero: assert property (
		reg_rd && reg_addr > FTS_OFS_BYTE_THREE |=> reg_rdata == 8'h00) // RQ1
		else $error("Unmapped index did not read zero.");

endmodule // fts_timestamp_counter
`default_nettype wire

// *** fts_host_model.sv ***
`default_nettype none
// Host model on the register port; requests start at a falling edge.
module fts_host_model
	import fts_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Register port.
	output logic [FTS_ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle port at time zero.
	initial
	begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Write data is flipped once released, so a late sample shows up.
	task automatic wr(input logic [FTS_ADDR_W-1:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Read data stands until the next read, so it is taken a cycle late.
	task automatic rd(input logic [FTS_ADDR_W-1:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	// Block read from byte zero upward.
	task automatic blk(output logic [31:0] v);
		for (int i = 0; i < 4; i++)
			rd(FTS_OFS_BYTE_ZERO + 3'(i), v[8*i +: 8]);
	endtask
endmodule // fts_host_model
`default_nettype wire

// *** test_frame_timestamp_counter.sv ***
`default_nettype none
// Bench for the timestamp counter behind its register port.
module test_frame_timestamp_counter
	import fts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [FTS_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} fts_row_s;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic trx_halted = 1'b0;
	logic tx_cmd_strobe = 1'b0;
	logic tx_done = 1'b0;
	logic rx_frame_start_irq = 1'b0;
	logic [FTS_ADDR_W-1:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic pa_enable;
	logic [31:0] a;
	logic [31:0] b;
	logic [7:0] d;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int t1;
	int t2;
	// Index, byte written, byte expected back; the counter is off for the count rows.
	fts_row_s rows [5] = '{'{FTS_OFS_CONFIG, 8'hFF, 8'h1F}, '{FTS_OFS_CONFIG, 8'h00, 8'h00},
		'{FTS_OFS_BYTE_ZERO, 8'hAA, 8'h00}, '{FTS_OFS_BYTE_THREE, 8'hFF, 8'h00},
		'{3'h7, 8'h5A, 8'h00}};
	// Clock and a cycle count for measuring spans.
	always #10 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	fts_timestamp_counter dut(.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .trx_halted, .tx_cmd_strobe, .tx_done, .rx_frame_start_irq, .pa_enable);
	fts_host_model host(.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// Tick phase is unknown to the bench, so a count may be off by two.
	task automatic chk_cnt(input string n, input int span, input logic [31:0] g);
		int e;
		e = span * FTS_CNT_MHZ / FTS_MCLK_MHZ;
		total_checks++;
		if ((g + 2 >= e && g <= e + 2) !== 1'b1)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic pulse_rx();
		@(negedge mclk);
		rx_frame_start_irq = 1'b1;
		@(negedge mclk);
		rx_frame_start_irq = 1'b0;
	endtask
	// Transmit command, then wait for the amplifier under a bound.
	task automatic tx_start(output int t);
		int n;
		tx_cmd_strobe = 1'b1;
		@(negedge mclk);
		tx_cmd_strobe = 1'b0;
		n = 1;
		while (pa_enable !== 1'b1 && n < 400)
		begin
			@(negedge mclk);
			n++;
		end
		chk("amplifier delay", FTS_TX_BB_DELAY_CYC, n);
		t = cyc;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog well beyond the roughly 1500 cycles the tests need.
	initial
	begin
		#(20 * 20000);
		num_errors++;
		wrap_up();
	end
	// Main sequence.
	initial
	begin
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		host.rd(FTS_OFS_CONFIG, d);
		chk("config reset", FTS_CFG_RESET, d);
		chk("amplifier reset", 1'b0, pa_enable);
		foreach (rows[i])
		begin
			host.wr(rows[i].addr, rows[i].wdata);
			host.rd(rows[i].addr, d);
			chk("register row", rows[i].rdata, d);
		end
		$display("register rows done");
		host.wr(FTS_OFS_CONFIG, 8'h01);
		host.blk(a);
		repeat (500) @(negedge mclk);
		host.blk(b);
		chk_cnt("free run span", 512, b - a);
		$display("free run done");
		trx_halted = 1'b1;
		host.blk(a);
		repeat (100) @(negedge mclk);
		host.blk(b);
		chk("halted count", a, b);
		trx_halted = 1'b0;
		host.wr(FTS_OFS_CONFIG, 8'h00);
		host.blk(a);
		chk("disabled count", FTS_CNT_RESET, a);
		$display("halt and disable done");
		host.wr(FTS_OFS_CONFIG, 8'h0B);
		repeat (300) @(negedge mclk);
		pulse_rx();
		host.blk(a);
		chk_cnt("rx capture", 300, a);
		repeat (50) @(negedge mclk);
		host.blk(b);
		chk("capture holds", a, b);
		pulse_rx();
		host.blk(a);
		chk_cnt("rx clear", 76, a);
		$display("receive capture done");
		host.wr(FTS_OFS_CONFIG, 8'h15);
		tx_start(t1);
		tx_done = 1'b1;
		@(negedge mclk);
		tx_done = 1'b0;
		repeat (5) @(negedge mclk);
		chk("amplifier off", 1'b0, pa_enable);
		tx_start(t2);
		host.blk(a);
		chk_cnt("tx capture", t2 - t1, a);
		$display("transmit capture done");
		wrap_up();
	end
endmodule // test_frame_timestamp_counter
`default_nettype wire
